/* rtl/pxb_crossbar.sv */
// Priority crossbar, pin configuration registers and port latches
`default_nettype none
//
// Function
// [R01] Functions placed in fixed priority, UART first
// [R02] Function gets lowest free unskipped pin
// [R03] UART transmit on pin 4, receive pin 5
// [R04] Only pins P0.0 to P2.3 take functions
// [R05] Skip bits make pins count as taken
// [R06] Software skips pins used outside the crossbar
// [R07] SMBus and UART each take pins pairwise
// [R08] Leftover pins act as plain port pins
// [R09] Slave select pinned only in 4-wire mode
// [R10] Analog pins lose pullup, driver and receiver
// [R11] Input mode bit: 1 digital, 0 analog
// [R12] Reset leaves every pin digital input
// [R13] Output mode bit picks open-drain or push-pull
// [R14] SMBus pins always open-drain
// [R15] Pullup on open-drain pins unless disabled
// [R16] Pullup off while pin drives low
// [R17] Enable bit turns crossbar routing on
// [R18] Disabled crossbar keeps every driver off
// [R19] Port read returns pin level
// [R20] First select register bit layout
// [R21] Small packages skip port 1 pins 6, 7
// [R22] Software configures modes before enabling
// [R23] Second select register bit layout
// [R24] Capture field routes first n outputs
// [R25] Output mode ignored on analog pins
// [R26] Read-modify-write reads the port latch
// [R27] Remaining priority order after SPI
module pxb_crossbar
  import pxb_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 srst_i,
  // Register port
  input  wire pxb_sfr_req_t         sfr_req_i,
  output logic [7:0]                sfr_rdata_o,
  // Peripherals
  input  wire pxb_fn_out_t          fn_out_i,
  input  wire logic [1:0]           spi_select_mode_i,
  output pxb_fn_in_t                fn_in_o,
  // Pins
  input  wire logic [NUM_PINS-1:0]  pin_in_i,
  output logic [NUM_PINS-1:0]       pin_out_o,
  output logic [NUM_PINS-1:0]       pin_oe_o,
  output logic [NUM_PINS-1:0]       pin_pullup_o,
  output logic [NUM_PINS-1:0]       pin_rx_en_o
);

  logic [7:0]          crossbar_select_0_reg, crossbar_select_0_next;
  logic [7:0]          crossbar_select_1_reg, crossbar_select_1_next;
  logic [NUM_PINS-1:0] latch_reg, latch_next;
  logic [NUM_PINS-1:0] pin_input_mode_reg, pin_input_mode_next;
  logic [NUM_PINS-1:0] pin_output_mode_reg, pin_output_mode_next;
  logic [NUM_PINS-1:0] pin_skip_mask_reg, pin_skip_mask_next;
  logic [7:0]          rdata_next;
  logic [NUM_PINS-1:0] pin_meta_reg, pin_sync_reg;
  logic [NUM_PINS-1:0] pin_dig;
  logic [NUM_SLOTS-1:0] slot_en;
  logic [4:0]          pin_slot [NUM_PINS];
  pxb_fn_in_t          fn_in_next;
  logic [NUM_PINS-1:0] out_next, oe_next, pu_next;
  logic                xbar_en, uart_en;
  logic [2:0]          cex_sel;

  assign xbar_en = crossbar_select_1_reg[B1_XBAR]; // [R17]
  assign uart_en = xbar_en & crossbar_select_0_reg[B0_UART];
  assign cex_sel = crossbar_select_1_reg[B1_CEX_LSB +: 3];
  // Analog pins read as 1 and feed 1 to peripherals
  assign pin_dig = pin_sync_reg | ~pin_input_mode_reg; // [R10] [R11]

  // Register writes
  always_comb begin
    crossbar_select_0_next = crossbar_select_0_reg;
    crossbar_select_1_next = crossbar_select_1_reg;
    latch_next             = latch_reg;
    pin_input_mode_next    = pin_input_mode_reg;
    pin_output_mode_next   = pin_output_mode_reg;
    pin_skip_mask_next     = pin_skip_mask_reg;
    if (sfr_req_i.wr) begin
      case (sfr_req_i.addr)
        ADDR_CROSSBAR_SELECT_0:   crossbar_select_0_next = sfr_req_i.wdata; // [R20]
        ADDR_CROSSBAR_SELECT_1:   crossbar_select_1_next = sfr_req_i.wdata; // [R23]
        ADDR_PORT0:  latch_next[7:0]   = sfr_req_i.wdata;
        ADDR_PORT1:  latch_next[15:8]  = sfr_req_i.wdata;
        ADDR_PORT2:  latch_next[23:16] = sfr_req_i.wdata;
        ADDR_MDIN0:  pin_input_mode_next[7:0]   = sfr_req_i.wdata;
        ADDR_MDIN1:  pin_input_mode_next[15:8]  = sfr_req_i.wdata;
        ADDR_MDIN2:  pin_input_mode_next[23:16] = sfr_req_i.wdata;
        ADDR_MDOUT0: pin_output_mode_next[7:0]   = sfr_req_i.wdata;
        ADDR_MDOUT1: pin_output_mode_next[15:8]  = sfr_req_i.wdata;
        ADDR_MDOUT2: pin_output_mode_next[23:16] = sfr_req_i.wdata;
        ADDR_SKIP0:  pin_skip_mask_next[7:0]   = sfr_req_i.wdata;
        ADDR_SKIP1:  pin_skip_mask_next[15:8]  = sfr_req_i.wdata;
        ADDR_SKIP2:  pin_skip_mask_next[23:16] = sfr_req_i.wdata;
        default: ;
      endcase
    end
  end

  // Register reads; unmapped addresses answer zero
  always_comb begin
    rdata_next = sfr_rdata_o;
    if (sfr_req_i.rd) begin
      case (sfr_req_i.addr)
        ADDR_CROSSBAR_SELECT_0:   rdata_next = crossbar_select_0_reg;
        ADDR_CROSSBAR_SELECT_1:   rdata_next = crossbar_select_1_reg;
        ADDR_PORT0:  rdata_next = sfr_req_i.rmw ? latch_reg[7:0]   : pin_dig[7:0];   // [R19] [R26]
        ADDR_PORT1:  rdata_next = sfr_req_i.rmw ? latch_reg[15:8]  : pin_dig[15:8];  // [R19] [R26]
        ADDR_PORT2:  rdata_next = sfr_req_i.rmw ? latch_reg[23:16] : pin_dig[23:16]; // [R19] [R26]
        ADDR_MDIN0:  rdata_next = pin_input_mode_reg[7:0];
        ADDR_MDIN1:  rdata_next = pin_input_mode_reg[15:8];
        ADDR_MDIN2:  rdata_next = pin_input_mode_reg[23:16];
        ADDR_MDOUT0: rdata_next = pin_output_mode_reg[7:0];
        ADDR_MDOUT1: rdata_next = pin_output_mode_reg[15:8];
        ADDR_MDOUT2: rdata_next = pin_output_mode_reg[23:16];
        ADDR_SKIP0:  rdata_next = pin_skip_mask_reg[7:0];
        ADDR_SKIP1:  rdata_next = pin_skip_mask_reg[15:8];
        ADDR_SKIP2:  rdata_next = pin_skip_mask_reg[23:16];
        default:     rdata_next = 8'h00;
      endcase
    end
  end

  // Slot enables in priority order
  always_comb begin
    slot_en = '0;
    if (xbar_en) begin
      slot_en[SL_SCK]  = crossbar_select_0_reg[B0_SPI];
      slot_en[SL_MISO] = crossbar_select_0_reg[B0_SPI];
      slot_en[SL_MOSI] = crossbar_select_0_reg[B0_SPI];
      slot_en[SL_NSS]  = crossbar_select_0_reg[B0_SPI] &
                         (spi_select_mode_i != SPI_MODE_3WIRE); // [R09]
      slot_en[SL_SDA]  = crossbar_select_0_reg[B0_SMB]; // [R07]
      slot_en[SL_SCL]  = crossbar_select_0_reg[B0_SMB]; // [R07]
      slot_en[SL_CP0]  = crossbar_select_0_reg[B0_CP0];
      slot_en[SL_CP0A] = crossbar_select_0_reg[B0_CP0A];
      slot_en[SL_CP1]  = crossbar_select_0_reg[B0_CP1];
      slot_en[SL_CP1A] = crossbar_select_0_reg[B0_CP1A];
      slot_en[SL_SYSC] = crossbar_select_0_reg[B0_SYSC]; // [R27]
      for (int k = 0; k < 5; k++) begin
        slot_en[int'(SL_CEX0) + k] = (cex_sel > 3'(k)); // [R24]
      end
      slot_en[SL_ECI]  = crossbar_select_1_reg[B1_ECI];
      slot_en[SL_T0]   = crossbar_select_1_reg[B1_T0];
      slot_en[SL_T1]   = crossbar_select_1_reg[B1_T1];
    end
  end

  // Walk the pins upward, handing each free pin the next enabled slot
  always_comb begin
    logic [4:0] nxt;
    logic       found;
    nxt   = 5'h00;
    found = 1'b0;
    fn_in_next.val     = '1;
    fn_in_next.uart_rx = uart_en ? pin_dig[UART_RX_PIN] : 1'b1; // [R03]
    for (int p = 0; p < NUM_PINS; p++) begin
      pin_slot[p] = SL_NONE;
      found = 1'b0;
      // Only the first twenty pins are eligible
      if (p < XBAR_PINS && !pin_skip_mask_reg[p] && // [R04] [R05]
          !(uart_en && (p == UART_TX_PIN || p == UART_RX_PIN))) begin // [R07]
        for (int k = 0; k < NUM_SLOTS; k++) begin
          if (!found && 5'(k) >= nxt && slot_en[k]) begin // [R01] [R02] [R27]
            pin_slot[p] = 5'(k);
            nxt = 5'(k + 1);
            found = 1'b1;
            fn_in_next.val[k] = pin_dig[p];
          end
        end
      end
    end
  end

  // Per-pin driver, mode and pullup decisions
  for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
    logic is_slot, is_uart, is_smb, val, want, od;
    assign is_slot = (pin_slot[p] != SL_NONE);
    assign is_uart = uart_en && (p == UART_TX_PIN || p == UART_RX_PIN);
    assign is_smb  = (pin_slot[p] == SL_SDA) || (pin_slot[p] == SL_SCL);
    // Leftover pins fall back to the port latch
    assign val  = (is_uart && p == UART_TX_PIN) ? fn_out_i.uart_tx : // [R03]
                  is_slot ? fn_out_i.val[pin_slot[p]] : latch_reg[p]; // [R08]
    assign want = is_uart ? (p == UART_TX_PIN) :
                  is_slot ? fn_out_i.drive[pin_slot[p]] : 1'b1;
    assign od   = ~pin_output_mode_reg[p] | is_smb; // [R13] [R14]
    // An open-drain high is released, never driven
    assign oe_next[p] = xbar_en & pin_input_mode_reg[p] & want & // [R18] [R10] [R25]
                        (~od | ~val);
    assign out_next[p] = val;
    assign pu_next[p]  = pin_input_mode_reg[p] & od & // [R15] [R10]
                         ~crossbar_select_1_reg[B1_WPUD] & ~(oe_next[p] & ~val); // [R16]
  end

  always_ff @(posedge clk_i) begin
    pin_meta_reg <= pin_in_i;
    pin_sync_reg <= pin_meta_reg;
    if (srst_i) begin
      crossbar_select_0_reg <= RST_XBR;
      crossbar_select_1_reg <= RST_XBR;
      latch_reg             <= {3{RST_LATCH}};
      pin_input_mode_reg    <= {3{RST_MDIN}}; // [R12]
      pin_output_mode_reg   <= {3{RST_MDOUT}};
      pin_skip_mask_reg     <= {3{RST_SKIP}};
      sfr_rdata_o           <= 8'h00;
      fn_in_o               <= '1;
      pin_out_o             <= '0;
      pin_oe_o              <= '0;
      pin_pullup_o          <= '0;
      pin_rx_en_o           <= '0;
    end else begin
      crossbar_select_0_reg <= crossbar_select_0_next;
      crossbar_select_1_reg <= crossbar_select_1_next;
      latch_reg             <= latch_next;
      pin_input_mode_reg    <= pin_input_mode_next;
      pin_output_mode_reg   <= pin_output_mode_next;
      pin_skip_mask_reg     <= pin_skip_mask_next;
      sfr_rdata_o           <= rdata_next;
      fn_in_o               <= fn_in_next;
      pin_out_o             <= out_next;
      pin_oe_o              <= oe_next;
      pin_pullup_o          <= pu_next;
      pin_rx_en_o           <= pin_input_mode_reg; // [R10]
    end
  end

  xbar_off_a: assert property (@(posedge clk_i) disable iff (srst_i) // [R18]
    !xbar_en |=> pin_oe_o == '0) else $error("driver on with crossbar off");
  uart_tx_a: assert property (@(posedge clk_i) disable iff (srst_i) // [R03]
    uart_en && pin_input_mode_reg[UART_TX_PIN] && pin_output_mode_reg[UART_TX_PIN]
    |=> pin_oe_o[UART_TX_PIN] && pin_out_o[UART_TX_PIN] == $past(fn_out_i.uart_tx))
    else $error("uart transmit not on pin 4");
  analog_pin_a: assert property (@(posedge clk_i) disable iff (srst_i) // [R10]
    !pin_input_mode_reg[0] |=> !pin_oe_o[0] && !pin_pullup_o[0] && !pin_rx_en_o[0])
    else $error("analog pin still digital");
  pullup_low_a: assert property (@(posedge clk_i) disable iff (srst_i) // [R16]
    (pin_oe_o & ~pin_out_o & pin_pullup_o) == '0) else $error("pullup on a low pin");
  rmw_latch_a: assert property (@(posedge clk_i) disable iff (srst_i) // [R26]
    sfr_req_i.rd && sfr_req_i.rmw && sfr_req_i.addr == ADDR_PORT0
    |=> sfr_rdata_o == $past(latch_reg[7:0])) else $error("rmw did not read latch");
  pin_read_a: assert property (@(posedge clk_i) disable iff (srst_i) // [R19]
    sfr_req_i.rd && !sfr_req_i.rmw && sfr_req_i.addr == ADDR_PORT1 &&
    pin_input_mode_reg[15:8] == 8'hFF |=> sfr_rdata_o == $past(pin_sync_reg[15:8]))
    else $error("port read not pin level");
  first_pin_a: assert property (@(posedge clk_i) disable iff (srst_i) // [R02]
    xbar_en && crossbar_select_0_reg[B0_SPI] && !pin_skip_mask_reg[0]
    |-> pin_slot[0] == SL_SCK) else $error("spi clock not on first free pin");
  skip_pin_a: assert property (@(posedge clk_i) disable iff (srst_i) // [R05]
    pin_skip_mask_reg[1] |-> pin_slot[1] == SL_NONE) else $error("skipped pin assigned");
  smbus_od_a: assert property (@(posedge clk_i) disable iff (srst_i) // [R14]
    pin_slot[2] == SL_SDA |=> !(pin_oe_o[2] && pin_out_o[2]))
    else $error("smbus pin driven high");
  reset_mode_a: assert property (@(posedge clk_i) // [R12]
    srst_i |=> pin_input_mode_reg == '1 && pin_oe_o == '0)
    else $error("pins not digital inputs after reset");

endmodule
`default_nettype wire

/* inc/pxb_pkg.sv */
// Constants and carrier types for the port crossbar block
`default_nettype none
package pxb_pkg;
  localparam int NUM_PINS  = 24;
  localparam int XBAR_PINS = 20;
  localparam int NUM_SLOTS = 19;
  localparam int UART_TX_PIN = 4;
  localparam int UART_RX_PIN = 5;

  // Register addresses
  localparam logic [7:0] ADDR_CROSSBAR_SELECT_0   = 8'hE1;
  localparam logic [7:0] ADDR_CROSSBAR_SELECT_1   = 8'hE2;
  localparam logic [7:0] ADDR_PORT0  = 8'h80;
  localparam logic [7:0] ADDR_PORT1  = 8'h90;
  localparam logic [7:0] ADDR_PORT2  = 8'hA0;
  localparam logic [7:0] ADDR_MDIN0  = 8'hF1;
  localparam logic [7:0] ADDR_MDIN1  = 8'hF2;
  localparam logic [7:0] ADDR_MDIN2  = 8'hF3;
  localparam logic [7:0] ADDR_MDOUT0 = 8'hA4;
  localparam logic [7:0] ADDR_MDOUT1 = 8'hA5;
  localparam logic [7:0] ADDR_MDOUT2 = 8'hA6;
  localparam logic [7:0] ADDR_SKIP0  = 8'hD4;
  localparam logic [7:0] ADDR_SKIP1  = 8'hD5;
  localparam logic [7:0] ADDR_SKIP2  = 8'hD6;

  // Reset values
  localparam logic [7:0] RST_XBR   = 8'h00;
  localparam logic [7:0] RST_LATCH = 8'hFF;
  localparam logic [7:0] RST_MDIN  = 8'hFF;
  localparam logic [7:0] RST_MDOUT = 8'h00;
  localparam logic [7:0] RST_SKIP  = 8'h00;

  // Field positions in the select registers
  localparam int B0_UART = 0;
  localparam int B0_SPI  = 1;
  localparam int B0_SMB  = 2;
  localparam int B0_SYSC = 3;
  localparam int B0_CP0  = 4;
  localparam int B0_CP0A = 5;
  localparam int B0_CP1  = 6;
  localparam int B0_CP1A = 7;
  localparam int B1_CEX_LSB = 0;
  localparam int B1_ECI  = 3;
  localparam int B1_T0   = 4;
  localparam int B1_T1   = 5;
  localparam int B1_XBAR = 6;
  localparam int B1_WPUD = 7;
  localparam logic [1:0] SPI_MODE_3WIRE = 2'b00;

  // Crossbar slots in priority order after the fixed UART pair
  localparam logic [4:0] SL_SCK  = 5'h00;
  localparam logic [4:0] SL_MISO = 5'h01;
  localparam logic [4:0] SL_MOSI = 5'h02;
  localparam logic [4:0] SL_NSS  = 5'h03;
  localparam logic [4:0] SL_SDA  = 5'h04;
  localparam logic [4:0] SL_SCL  = 5'h05;
  localparam logic [4:0] SL_CP0  = 5'h06;
  localparam logic [4:0] SL_CP0A = 5'h07;
  localparam logic [4:0] SL_CP1  = 5'h08;
  localparam logic [4:0] SL_CP1A = 5'h09;
  localparam logic [4:0] SL_SYSC = 5'h0A;
  localparam logic [4:0] SL_CEX0 = 5'h0B;
  localparam logic [4:0] SL_ECI  = 5'h10;
  localparam logic [4:0] SL_T0   = 5'h11;
  localparam logic [4:0] SL_T1   = 5'h12;
  localparam logic [4:0] SL_NONE = 5'h1F;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic       rmw;
    logic [7:0] wdata;
  } pxb_sfr_req_t;

  typedef struct packed {
    logic [NUM_SLOTS-1:0] val;
    logic [NUM_SLOTS-1:0] drive;
    logic                 uart_tx;
  } pxb_fn_out_t;

  typedef struct packed {
    logic [NUM_SLOTS-1:0] val;
    logic                 uart_rx;
  } pxb_fn_in_t;
endpackage
`default_nettype wire

/* verif/pxb_pin_model.sv */
// Board-side pad model that resolves each pin from the device drivers and the board
`default_nettype none
module pxb_pin_model
  import pxb_pkg::*;
(
  // Device side
  input  wire logic [NUM_PINS-1:0] pin_out_i,
  input  wire logic [NUM_PINS-1:0] pin_oe_i,
  input  wire logic [NUM_PINS-1:0] pin_pullup_i,
  // Board side
  input  wire logic [NUM_PINS-1:0] board_val_i,
  input  wire logic [NUM_PINS-1:0] board_en_i,
  output logic [NUM_PINS-1:0]      pin_lvl_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // A floating pad with no pullup reads the inverse of the board value, so a stale level never
  // passes for a good one
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      if (pin_oe_i[i]) begin
        pin_lvl_o[i] = pin_out_i[i];
      end else if (board_en_i[i]) begin
        pin_lvl_o[i] = board_val_i[i];
      end else begin
        pin_lvl_o[i] = pin_pullup_i[i] | ~board_val_i[i];
      end
    end
  end
endmodule
`default_nettype wire

/* verif/tb_priority_crossbar_port_io.sv */
// Self-checking bench for the port crossbar
`default_nettype none
module tb_priority_crossbar_port_io
  import pxb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic                clk_i = 1'b0;
  logic                srst_i = 1'b1;
  pxb_sfr_req_t        req = '0;
  pxb_fn_out_t         fo = '0;
  pxb_fn_in_t          fi;
  logic [1:0]          smode = 2'b00;
  logic [7:0]          rdata;
  logic [NUM_PINS-1:0] lvl, p_out, p_oe, p_pu, p_rx;
  logic [NUM_PINS-1:0] bval = '0;
  logic [NUM_PINS-1:0] ben = '0;
  logic [7:0]          x0, x1;
  logic [7:0]          skp[3], mdi[3], mdo[3], lat[3];
  logic [7:0]          expq[$];
  logic                rd_d = 1'b0;
  int                  n_fail = 0;
  int                  compares = 0;
  int                  seed = 76448;

  always #20 clk_i = ~clk_i;

  pxb_crossbar dut_u (
    .clk_i(clk_i), .srst_i(srst_i), .sfr_req_i(req), .sfr_rdata_o(rdata), .fn_out_i(fo),
    .spi_select_mode_i(smode), .fn_in_o(fi), .pin_in_i(lvl), .pin_out_o(p_out),
    .pin_oe_o(p_oe), .pin_pullup_o(p_pu), .pin_rx_en_o(p_rx));
  pxb_pin_model pm_u (.pin_out_i(p_out), .pin_oe_i(p_oe), .pin_pullup_i(p_pu),
    .board_val_i(bval), .board_en_i(ben), .pin_lvl_o(lvl));

  task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
    compares++;
    if (s !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic test_done();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Requests are held until the next edge; idle() releases them
  task automatic wr(logic [7:0] a, logic [7:0] d);
    req <= '{addr: a, wr: 1'b1, rd: 1'b0, rmw: 1'b0, wdata: d};
    @(posedge clk_i);
  endtask

  task automatic rd(logic [7:0] a, logic m, logic [7:0] e);
    expq.push_back(e);
    req <= '{addr: a, wr: 1'b0, rd: 1'b1, rmw: m, wdata: 8'h00};
    @(posedge clk_i);
  endtask

  task automatic idle();
    req <= '0;
    repeat (2) @(posedge clk_i);
  endtask

  // Read data lands one edge after the request is taken
  always @(posedge clk_i) begin
    rd_d <= req.rd;
    if (rd_d) chk("sfr_rdata", expq.pop_front(), rdata);
  end

  function automatic void map(output int pof[NUM_SLOTS]);
    logic [XBAR_PINS-1:0] tk;
    logic [NUM_SLOTS-1:0] en;
    int                   p;
    tk = {skp[2][3:0], skp[1], skp[0]};
    if (x0[B0_UART]) tk[5:4] = 2'b11;
    en = '0;
    en[2:0] = {3{x0[B0_SPI]}};
    en[3] = x0[B0_SPI] && smode != SPI_MODE_3WIRE;
    en[5:4] = {2{x0[B0_SMB]}};
    en[9:6] = {x0[B0_CP1A], x0[B0_CP1], x0[B0_CP0A], x0[B0_CP0]};
    en[10] = x0[B0_SYSC];
    for (int i = 0; i < 5; i++) en[11+i] = i < x1[2:0];
    en[18:16] = {x1[B1_T1], x1[B1_T0], x1[B1_ECI]};
    if (!x1[B1_XBAR]) en = '0;
    p = 0;
    // Slot indices follow the priority order, so one forward sweep places them all
    for (int s = 0; s < NUM_SLOTS; s++) begin
      pof[s] = -1;
      while (p < XBAR_PINS && tk[p]) p++;
      if (en[s] && p < XBAR_PINS) begin
        pof[s] = p;
        p++;
      end
    end
  endfunction

  task automatic check_pins();
    int                   pof[NUM_SLOTS];
    logic [NUM_PINS-1:0]  src, eo, ep, dig, pp, lv, pm;
    logic [NUM_SLOTS-1:0] fe;
    logic                 xe;
    xe = x1[B1_XBAR];
    dig = {mdi[2], mdi[1], mdi[0]};
    pp = {mdo[2], mdo[1], mdo[0]};
    src = {lat[2], lat[1], lat[0]};
    pm = '1;
    map(pof);
    if (xe && x0[B0_UART]) begin
      src[UART_TX_PIN] = fo.uart_tx;
      pm[UART_RX_PIN]  = 1'b0;
    end
    // Input-only functions never drive, but their pad keeps its own output mode for the pullup
    for (int s = 0; s < NUM_SLOTS; s++) begin
      if (pof[s] >= 0) begin
        src[pof[s]] = fo.val[s];
        if (s == 4 || s == 5) pp[pof[s]] = 1'b0;
        pm[pof[s]] = fo.drive[s];
      end
    end
    eo = {NUM_PINS{xe}} & dig & pm & (pp | ~src);
    ep = dig & ~pp & ~(eo & ~src) & {NUM_PINS{~x1[B1_WPUD]}};
    for (int p = 0; p < NUM_PINS; p++) lv[p] = eo[p] ? src[p] : ben[p] ? bval[p] : ep[p] | ~bval[p];
    fe = '1;
    for (int s = 0; s < NUM_SLOTS; s++) if (pof[s] >= 0 && dig[pof[s]]) fe[s] = lv[pof[s]];
    chk("pin_oe", eo, p_oe);
    chk("pin_out", src & eo, p_out & eo);
    chk("pin_pullup", ep, p_pu);
    chk("pin_rx_en", dig, p_rx);
    chk("fn_in", fe, fi.val);
    chk("uart_rx", (xe && x0[B0_UART] && dig[5]) ? lv[5] : 1'b1, fi.uart_rx);
    for (int i = 0; i < 3; i++) begin
      rd(8'(ADDR_PORT0 + 16 * i), 1'b0, lv[8*i+:8] | ~dig[8*i+:8]);
      rd(8'(ADDR_PORT0 + 16 * i), 1'b1, lat[i]);
    end
    rd(ADDR_CROSSBAR_SELECT_0, 1'b0, x0);
    rd(ADDR_CROSSBAR_SELECT_1, 1'b0, x1);
    idle();
  endtask

  task automatic apply();
    for (int i = 0; i < 3; i++) wr(8'(ADDR_MDIN0 + i), mdi[i]);
    for (int i = 0; i < 3; i++) wr(8'(ADDR_MDOUT0 + i), mdo[i]);
    for (int i = 0; i < 3; i++) wr(8'(ADDR_SKIP0 + i), skp[i]);
    for (int i = 0; i < 3; i++) wr(8'(ADDR_PORT0 + 16 * i), lat[i]);
    wr(ADDR_CROSSBAR_SELECT_0, x0);
    wr(ADDR_CROSSBAR_SELECT_1, x1);
    idle();
    // Two edges to the pins, then two through the input synchroniser and one into fn_in_o
    repeat (6) @(posedge clk_i);
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    $display("watchdog expired");
    test_done();
  end

  initial begin
    repeat (10) @(posedge clk_i);
    srst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk("reset oe", 32'h0, p_oe);
    chk("reset rx_en", {NUM_PINS{1'b1}}, p_rx);
    chk("reset pullup", {NUM_PINS{1'b1}}, p_pu);
    rd(ADDR_CROSSBAR_SELECT_0, 1'b0, RST_XBR);
    rd(ADDR_CROSSBAR_SELECT_1, 1'b0, RST_XBR);
    rd(ADDR_MDIN0, 1'b0, RST_MDIN);
    rd(ADDR_MDOUT0, 1'b0, RST_MDOUT);
    rd(ADDR_SKIP0, 1'b0, RST_SKIP);
    rd(ADDR_PORT0, 1'b1, RST_LATCH);
    rd(8'h00, 1'b0, 8'h00);
    idle();
    $display("test reset done");
    for (int it = 0; it < 40; it++) begin
      x0 = 8'($random(seed));
      x1 = 8'($random(seed));
      x1[B1_XBAR] = (it % 5) != 4;
      for (int i = 0; i < 3; i++) begin
        skp[i] = 8'($random(seed));
        mdi[i] = 8'($random(seed) | $random(seed));
        mdo[i] = 8'($random(seed));
        lat[i] = 8'($random(seed));
      end
      // The receive pin is kept released so either reading of it gives the same pad
      lat[0][5] = 1'b1;
      mdo[0][5] = 1'b0;
      if (it == 0) begin
        x0 = 8'h07;
        x1 = 8'h45;
        skp[0] = 8'h0C;
        skp[1][7:6] = 2'b11;
        mdi = '{default: 8'hFF};
      end
      fo <= '{val: 19'($random(seed)), drive: 19'h0FFFF, uart_tx: 1'($random(seed))};
      smode <= 2'($random(seed));
      bval <= 24'($random(seed));
      ben <= 24'($random(seed));
      apply();
      check_pins();
      $display("test config %0d done", it);
    end
    test_done();
  end
endmodule
`default_nettype wire
